// file: urhpc_pkg.sv
// Constants and types shared by the root hub port control logic
package urhpc_pkg;
    localparam int PORT_CNT = 2;
    localparam logic [7:0] OFF_PORT1 = 8'h10;
    localparam logic [7:0] OFF_PORT2 = 8'h12;
    localparam logic [15:0] PORT_RESET_VAL = 16'h0000;
    localparam logic [1:0] WORD_LANES = 2'h3;
    // Field positions of port_status_control
    localparam int B_CONN = 0;
    localparam int B_CONN_CHG = 1;
    localparam int B_EN = 2;
    localparam int B_EN_CHG = 3;
    localparam int B_LINE_DP = 4;
    localparam int B_LINE_DM = 5;
    localparam int B_RESUME = 6;
    localparam int B_RSVD_ONE = 7;
    localparam int B_LOW_SPEED = 8;
    localparam int B_PRESET = 9;
    localparam int B_SUSPEND = 12;
    localparam logic [1:0] LINE_SE0 = 2'h0;
    // Timing in full-speed bit times
    localparam logic [5:0] CONN_DEB_BITS = 6'h20;
    localparam logic [4:0] EOP_SE0_BITS = 5'h10;
    localparam logic [4:0] EOP_J_BITS = 5'h08;
    typedef enum logic [2:0] {
        DRV_IDLE = 3'h1,
        DRV_SE0 = 3'h2,
        DRV_J = 3'h4
    } urhpc_drv_e;
endpackage

// file: urhpc_line_if.sv
// Line signals and connect status passed between port control and line monitor
`timescale 1ns/10ps
interface urhpc_line_if;
    logic dp;
    logic dm;
    logic driving;
    logic connected;
    logic low_speed;
    logic j_to_k;
    modport mon (input dp, input dm, input driving,
                 output connected, output low_speed, output j_to_k);
    modport ctl (output dp, output dm, output driving,
                 input connected, input low_speed, input j_to_k);
endinterface

// file: urhpc_line_mon.sv
// Per-port line monitor: connect debounce, speed detect, J-to-K detect
`timescale 1ns/10ps
module urhpc_line_mon (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bit_en_i,
    urhpc_line_if.mon line
);
    logic [5:0] deb_cnt_ff, nxt_deb_cnt;
    logic conn_ff, nxt_conn;
    logic ls_ff, nxt_ls;
    logic prev_j_ff, nxt_prev_j;
    logic jk_ff, nxt_jk;
    logic se0;
    logic k_now;

    localparam logic [5:0] CONN_DEB_BITS = urhpc_pkg::CONN_DEB_BITS;

    always_comb begin
        se0 = !line.dp && !line.dm;
        k_now = ls_ff ? (line.dp && !line.dm) : (!line.dp && line.dm);
        nxt_deb_cnt = deb_cnt_ff;
        nxt_conn = conn_ff;
        nxt_ls = ls_ff;
        nxt_prev_j = prev_j_ff;
        nxt_jk = 1'b0;
        if (line.driving) begin
            nxt_deb_cnt = 6'h00;
            nxt_prev_j = 1'b0;
        end else begin
            // Connect settles within CONN_DEB_BITS bit times
            if (bit_en_i) begin
                if (se0 == conn_ff) begin
                    if (deb_cnt_ff == CONN_DEB_BITS - 6'h01) begin
                        nxt_conn = !conn_ff;
                        nxt_ls = line.dm && !line.dp;
                        nxt_deb_cnt = 6'h00;
                    end else begin
                        nxt_deb_cnt = deb_cnt_ff + 6'h01;
                    end
                end else begin
                    nxt_deb_cnt = 6'h00;
                end
            end
            nxt_jk = conn_ff && prev_j_ff && k_now;
            nxt_prev_j = ls_ff ? (!line.dp && line.dm) : (line.dp && !line.dm);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deb_cnt_ff <= 6'h00;
            conn_ff <= 1'b0;
            ls_ff <= 1'b0;
            prev_j_ff <= 1'b0;
            jk_ff <= 1'b0;
        end else begin
            deb_cnt_ff <= nxt_deb_cnt;
            conn_ff <= nxt_conn;
            ls_ff <= nxt_ls;
            prev_j_ff <= nxt_prev_j;
            jk_ff <= nxt_jk;
        end
    end

    assign line.connected = conn_ff;
    assign line.low_speed = ls_ff;
    assign line.j_to_k = jk_ff;

    chk_conn_deb_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (conn_ff != $past(conn_ff)) |-> ($past(deb_cnt_ff) == CONN_DEB_BITS - 6'h01))
        else $error("connect status changed without full debounce");
endmodule

// file: urhpc_port_ctl.sv
// Status and control logic for the two root hub downstream ports
//
// Behaviour
// - After reset: disconnected, disabled, line status reads 00.
// - An attached device shows connected with change flag after 32 bit times.
// - In global suspend, setting bits 6, 3 or 1 requests a resume.
// - Enable and suspend bits give disabled, enabled or suspended port state.
// - Suspended port blocks downstream data except SE0 resets; answers resume.
// - Suspend waits for the running transaction; bit reads set once suspended.
// - While port reset is set, port is disabled and drives SE0 reset.
// - Speed bit reads 1 for low speed, 0 for full speed; read only.
// - Reserved bit 7 always reads 1.
// - Resume detect set by J-to-K on suspended port, or by software.
// - Resume detect set on a suspended port drives K continuously.
// - Clearing resume detect sends low-speed EOP; bit reads 1 until done.
// - Line status bits give D+ in bit 4, D- in bit 5, at EOF2.
// - Enable change set only on disconnect or EOF2 fault; write 1 clears.
// - Only software enables; disconnect, faults or software disable.
// - Enable shows real state; disable waits for running transaction.
// - Connect change set on every connect change; write 1 clears.
// - Bit 0 shows present connect status, read only.
`timescale 1ns/10ps
module urhpc_port_ctl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bit_en_i,
    input wire logic [7:0] io_off_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [1:0] io_be_i,
    input wire logic [15:0] io_wdata_i,
    input wire logic global_suspend_i,
    input wire logic global_reset_i,
    input wire logic eof2_i,
    input wire logic xact_busy_i,
    input wire logic tx_dp_i,
    input wire logic tx_dm_i,
    input wire logic tx_oe_i,
    input wire logic [1:0] dp_i,
    input wire logic [1:0] dm_i,
    output logic [15:0] io_rdata_o,
    output logic resume_req_o,
    output logic [1:0] dp_o,
    output logic [1:0] dm_o,
    output logic [1:0] oe_o
);
    localparam int NP = urhpc_pkg::PORT_CNT;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    function automatic logic port_hit(input logic [7:0] off, input int p);
        port_hit = (off == ((p == 0) ? urhpc_pkg::OFF_PORT1 : urhpc_pkg::OFF_PORT2));
    endfunction

    // K state is opposite polarity for low speed
    function automatic logic [1:0] k_state(input logic low);
        k_state = low ? 2'h1 : 2'h2;
    endfunction

    //------------------------------------------------------------
    // Line monitors
    //------------------------------------------------------------
    urhpc_line_if lif[NP]();
    logic [1:0] conn_w;
    logic [1:0] ls_w;
    logic [1:0] jk_w;

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_mon
            assign lif[g].dp = dp_i[g];
            assign lif[g].dm = dm_i[g];
            assign lif[g].driving = oe_o[g];
            assign conn_w[g] = lif[g].connected;
            assign ls_w[g] = lif[g].low_speed;
            assign jk_w[g] = lif[g].j_to_k;
            urhpc_line_mon u_mon (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .bit_en_i(bit_en_i),
                .line(lif[g].mon)
            );
        end
    endgenerate

    //------------------------------------------------------------
    // Port status and control state
    //------------------------------------------------------------
    logic [1:0] conn_ff, nxt_conn;
    logic [1:0] cc_ff, nxt_cc;
    logic [1:0] en_ff, nxt_en;
    logic [1:0] ec_ff, nxt_ec;
    logic [1:0] susp_ff, nxt_susp;
    logic [1:0] sreq_ff, nxt_sreq;
    logic [1:0] dpend_ff, nxt_dpend;
    logic [1:0] prst_ff, nxt_prst;
    logic [1:0] res_ff, nxt_res;
    logic [1:0] line_ff [NP];
    logic [1:0] nxt_line [NP];
    urhpc_pkg::urhpc_drv_e drv_ff [NP];
    urhpc_pkg::urhpc_drv_e nxt_drv [NP];
    logic [4:0] eop_cnt_ff [NP];
    logic [4:0] nxt_eop_cnt [NP];
    logic resreq_ff, nxt_resreq;
    logic [1:0] wr_w;

    always_comb begin
        nxt_conn = conn_ff;
        nxt_cc = cc_ff;
        nxt_en = en_ff;
        nxt_ec = ec_ff;
        nxt_susp = susp_ff;
        nxt_sreq = sreq_ff;
        nxt_dpend = dpend_ff;
        nxt_prst = prst_ff;
        nxt_res = res_ff;
        nxt_resreq = 1'b0;
        wr_w = 2'h0;
        for (int p = 0; p < NP; p++) begin
            logic cc_set;
            logic ec_set;
            logic res_set;
            cc_set = 1'b0;
            ec_set = 1'b0;
            res_set = 1'b0;
            nxt_line[p] = line_ff[p];
            nxt_drv[p] = drv_ff[p];
            nxt_eop_cnt[p] = eop_cnt_ff[p];
            wr_w[p] = io_wr_i && (io_be_i == urhpc_pkg::WORD_LANES)
                      && port_hit(io_off_i, p);
            // Software side of the register
            if (wr_w[p]) begin
                if (io_wdata_i[urhpc_pkg::B_CONN_CHG]) nxt_cc[p] = 1'b0;
                if (io_wdata_i[urhpc_pkg::B_EN_CHG]) nxt_ec[p] = 1'b0;
                nxt_prst[p] = io_wdata_i[urhpc_pkg::B_PRESET];
                if (io_wdata_i[urhpc_pkg::B_EN]) begin
                    nxt_en[p] = conn_ff[p];
                    nxt_dpend[p] = 1'b0;
                end else if (en_ff[p]) begin
                    nxt_dpend[p] = 1'b1;
                end
                if (!io_wdata_i[urhpc_pkg::B_SUSPEND]) begin
                    nxt_susp[p] = 1'b0;
                    nxt_sreq[p] = 1'b0;
                end else if (!susp_ff[p]) begin
                    nxt_sreq[p] = 1'b1;
                end
                if (io_wdata_i[urhpc_pkg::B_RESUME]) begin
                    nxt_res[p] = 1'b1;
                    res_set = !res_ff[p];
                end else if (res_ff[p] && drv_ff[p] == urhpc_pkg::DRV_IDLE) begin
                    nxt_drv[p] = urhpc_pkg::DRV_SE0;
                    nxt_eop_cnt[p] = 5'h00;
                end
            end
            // Deferred suspend and disable wait for the bus to go quiet
            if (!xact_busy_i && dpend_ff[p]) begin
                nxt_en[p] = 1'b0;
                nxt_dpend[p] = 1'b0;
            end
            if (!xact_busy_i && sreq_ff[p] && en_ff[p]) begin
                nxt_susp[p] = 1'b1;
                nxt_sreq[p] = 1'b0;
            end
            // Babble across EOF2 counts as a port fault
            if (eof2_i && en_ff[p] && xact_busy_i) begin
                nxt_en[p] = 1'b0;
                ec_set = 1'b1;
            end
            if (eof2_i) begin
                nxt_line[p] = {dm_i[p], dp_i[p]};
            end
            if (jk_w[p] && susp_ff[p] && en_ff[p]) begin
                nxt_res[p] = 1'b1;
                res_set = !res_ff[p];
            end
            if (conn_w[p] != conn_ff[p]) begin
                nxt_conn[p] = conn_w[p];
                cc_set = 1'b1;
                if (!conn_w[p]) begin
                    nxt_en[p] = 1'b0;
                    ec_set = en_ff[p];
                end
            end
            if (prst_ff[p]) begin
                nxt_en[p] = 1'b0;
            end
            if (!nxt_en[p]) begin
                nxt_susp[p] = 1'b0;
                nxt_sreq[p] = 1'b0;
                nxt_dpend[p] = 1'b0;
            end
            // Low-speed EOP: two low-speed bits of SE0, then one of J
            if (bit_en_i) begin
                case (drv_ff[p])
                    urhpc_pkg::DRV_IDLE: begin
                        nxt_eop_cnt[p] = 5'h00;
                    end
                    urhpc_pkg::DRV_SE0: begin
                        if (eop_cnt_ff[p] == urhpc_pkg::EOP_SE0_BITS - 5'h01) begin
                            nxt_drv[p] = urhpc_pkg::DRV_J;
                            nxt_eop_cnt[p] = 5'h00;
                        end else begin
                            nxt_eop_cnt[p] = eop_cnt_ff[p] + 5'h01;
                        end
                    end
                    urhpc_pkg::DRV_J: begin
                        if (eop_cnt_ff[p] == urhpc_pkg::EOP_J_BITS - 5'h01) begin
                            nxt_drv[p] = urhpc_pkg::DRV_IDLE;
                            nxt_res[p] = 1'b0;
                        end else begin
                            nxt_eop_cnt[p] = eop_cnt_ff[p] + 5'h01;
                        end
                    end
                    default: begin
                        nxt_drv[p] = urhpc_pkg::DRV_IDLE;
                    end
                endcase
            end
            // Hardware set wins over a simultaneous write-1 clear
            if (cc_set) nxt_cc[p] = 1'b1;
            if (ec_set) nxt_ec[p] = 1'b1;
            if (global_suspend_i && (cc_set || ec_set || res_set)) begin
                nxt_resreq = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conn_ff <= 2'h0;
            cc_ff <= 2'h0;
            en_ff <= 2'h0;
            ec_ff <= 2'h0;
            susp_ff <= 2'h0;
            sreq_ff <= 2'h0;
            dpend_ff <= 2'h0;
            prst_ff <= 2'h0;
            res_ff <= 2'h0;
            resreq_ff <= 1'b0;
            for (int p = 0; p < NP; p++) begin
                line_ff[p] <= urhpc_pkg::LINE_SE0;
                drv_ff[p] <= urhpc_pkg::DRV_IDLE;
                eop_cnt_ff[p] <= 5'h00;
            end
        end else begin
            conn_ff <= nxt_conn;
            cc_ff <= nxt_cc;
            en_ff <= nxt_en;
            ec_ff <= nxt_ec;
            susp_ff <= nxt_susp;
            sreq_ff <= nxt_sreq;
            dpend_ff <= nxt_dpend;
            prst_ff <= nxt_prst;
            res_ff <= nxt_res;
            resreq_ff <= nxt_resreq;
            for (int p = 0; p < NP; p++) begin
                line_ff[p] <= nxt_line[p];
                drv_ff[p] <= nxt_drv[p];
                eop_cnt_ff[p] <= nxt_eop_cnt[p];
            end
        end
    end

    //------------------------------------------------------------
    // Pin drive and register read
    //------------------------------------------------------------
    logic [1:0] dp_ff, nxt_dp;
    logic [1:0] dm_ff, nxt_dm;
    logic [1:0] oe_ff, nxt_oe;
    logic [15:0] rdata_ff, nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        for (int p = 0; p < NP; p++) begin
            logic [1:0] k;
            k = k_state(ls_w[p]);
            nxt_oe[p] = 1'b0;
            nxt_dp[p] = 1'b0;
            nxt_dm[p] = 1'b0;
            if (prst_ff[p] || global_reset_i) begin
                nxt_oe[p] = 1'b1;
            end else if (drv_ff[p] == urhpc_pkg::DRV_SE0) begin
                nxt_oe[p] = 1'b1;
            end else if (drv_ff[p] == urhpc_pkg::DRV_J) begin
                nxt_oe[p] = 1'b1;
                nxt_dp[p] = k[1];
                nxt_dm[p] = k[0];
            end else if (susp_ff[p] && res_ff[p]) begin
                nxt_oe[p] = 1'b1;
                nxt_dp[p] = k[0];
                nxt_dm[p] = k[1];
            end else if (en_ff[p] && !susp_ff[p]) begin
                nxt_oe[p] = tx_oe_i;
                nxt_dp[p] = tx_dp_i;
                nxt_dm[p] = tx_dm_i;
            end
            if (io_rd_i && port_hit(io_off_i, p)) begin
                nxt_rdata = urhpc_pkg::PORT_RESET_VAL;
                nxt_rdata[urhpc_pkg::B_CONN] = conn_ff[p];
                nxt_rdata[urhpc_pkg::B_CONN_CHG] = cc_ff[p];
                nxt_rdata[urhpc_pkg::B_EN] = en_ff[p];
                nxt_rdata[urhpc_pkg::B_EN_CHG] = ec_ff[p];
                nxt_rdata[urhpc_pkg::B_LINE_DP] = line_ff[p][0];
                nxt_rdata[urhpc_pkg::B_LINE_DM] = line_ff[p][1];
                nxt_rdata[urhpc_pkg::B_RESUME] = res_ff[p];
                nxt_rdata[urhpc_pkg::B_RSVD_ONE] = 1'b1;
                nxt_rdata[urhpc_pkg::B_LOW_SPEED] = ls_w[p] && conn_ff[p];
                nxt_rdata[urhpc_pkg::B_PRESET] = prst_ff[p];
                nxt_rdata[urhpc_pkg::B_SUSPEND] = susp_ff[p];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_ff <= 2'h0;
            dm_ff <= 2'h0;
            oe_ff <= 2'h0;
            rdata_ff <= urhpc_pkg::PORT_RESET_VAL;
        end else begin
            dp_ff <= nxt_dp;
            dm_ff <= nxt_dm;
            oe_ff <= nxt_oe;
            rdata_ff <= nxt_rdata;
        end
    end

    assign dp_o = dp_ff;
    assign dm_o = dm_ff;
    assign oe_o = oe_ff;
    assign io_rdata_o = rdata_ff;
    assign resume_req_o = resreq_ff;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_eop_start;
        (drv_ff[0] == urhpc_pkg::DRV_IDLE) ##1 (drv_ff[0] == urhpc_pkg::DRV_SE0);
    endsequence

    chk_rsvd_one: assert property ((io_rd_i && port_hit(io_off_i, 0)) |=> io_rdata_o[7])
        else $error("reserved bit 7 read as 0");
    chk_disc_flags: assert property ((conn_ff[1] && !conn_w[1]) |=> (!en_ff[1] && cc_ff[1]))
        else $error("disconnect did not disable and flag port");
    chk_prst_dis: assert property (prst_ff[0] |=> !en_ff[0])
        else $error("port enabled during port reset");
    chk_prst_se0: assert property (prst_ff[0] |=> (oe_o[0] && !dp_o[0] && !dm_o[0]))
        else $error("port reset not driving SE0");
    chk_en_sw_only: assert property ($rose(en_ff[0]) |-> $past(wr_w[0]))
        else $error("port enabled without a software write");
    chk_susp_defer: assert property ((!susp_ff[0] && xact_busy_i) |=> !susp_ff[0])
        else $error("port suspended during a transaction");
    chk_resume_k: assert property ((susp_ff[0] && res_ff[0] && !prst_ff[0] && !global_reset_i
        && drv_ff[0] == urhpc_pkg::DRV_IDLE) |=> (oe_o[0] && (dp_o[0] != dm_o[0])))
        else $error("resume K not driven on suspended port");
    chk_eop_hold: assert property (s_eop_start |-> res_ff[0] throughout
        (drv_ff[0] != urhpc_pkg::DRV_IDLE) [*2])
        else $error("resume bit dropped before EOP completed");
    chk_resume_req: assert property (($rose(res_ff[0]) && $past(global_suspend_i))
        |-> resume_req_o)
        else $error("resume detect in global suspend did not request resume");
    chk_line_eof2: assert property (eof2_i |=> (line_ff[0] == {$past(dm_i[0]), $past(dp_i[0])}))
        else $error("line status not sampled at EOF2");
endmodule

// file: urhpc_dev_model.sv
// Behavioural USB device hanging on one downstream port
`timescale 1ns/10ps
module urhpc_dev_model (
    input wire logic attach_i,
    input wire logic low_speed_i,
    input wire logic k_i,
    input wire logic oe_i,
    input wire logic dp_i,
    input wire logic dm_i,
    output logic dp_o,
    output logic dm_o
);
    // Hub drive wins; pull-downs give SE0 when detached; idle is J
    always_comb begin
        if (oe_i) begin
            dp_o = dp_i;
            dm_o = dm_i;
        end else if (!attach_i) begin
            dp_o = 1'b0;
            dm_o = 1'b0;
        end else begin
            dp_o = low_speed_i ~^ k_i;
            dm_o = low_speed_i ^ k_i;
        end
    end
endmodule

// file: test_usb_root_hub_port_control.sv
// Self-checking testbench for the root hub port control logic
`timescale 1ns/10ps
module test_usb_root_hub_port_control;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic bit_en, io_wr, io_rd, gsusp, grst, eof2, busy, tdp, tdm, toe;
    logic [7:0] io_off;
    logic [1:0] io_be, att, ls, kst, ldp, ldm, dpo, dmo, oe;
    logic [1:0] bdiv = 2'h0;
    logic [15:0] io_wdata, io_rdata;
    logic [15:0] n_res = 16'h0000;
    logic res_req;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    // ----------------------------------------
    // Clock, bit enable, design and devices
    // ----------------------------------------
    always #10 clk_i = ~clk_i;
    always @(negedge clk_i) bdiv <= bdiv + 2'h1;
    assign bit_en = (bdiv == 2'h0);
    urhpc_port_ctl urhpc_port_ctl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bit_en_i(bit_en),
        .io_off_i(io_off), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_be_i(io_be),
        .io_wdata_i(io_wdata), .global_suspend_i(gsusp), .global_reset_i(grst),
        .eof2_i(eof2), .xact_busy_i(busy), .tx_dp_i(tdp), .tx_dm_i(tdm), .tx_oe_i(toe),
        .dp_i(ldp), .dm_i(ldm), .io_rdata_o(io_rdata), .resume_req_o(res_req),
        .dp_o(dpo), .dm_o(dmo), .oe_o(oe));
    for (genvar i = 0; i < 2; i++) begin : g_dev
        urhpc_dev_model urhpc_dev_model_inst (.attach_i(att[i]), .low_speed_i(ls[i]),
            .k_i(kst[i]), .oe_i(oe[i]), .dp_i(dpo[i]), .dm_i(dmo[i]),
            .dp_o(ldp[i]), .dm_o(ldm[i]));
    end
    always @(posedge clk_i) begin
        if (res_req === 1'b1) n_res <= n_res + 16'h0001;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            test_done();
        end
    end
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] off, input logic [15:0] d, input logic [1:0] be);
        @(negedge clk_i);
        io_off = off;
        io_wdata = d;
        io_be = be;
        io_wr = 1'b1;
        @(negedge clk_i);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] off, input logic [15:0] e);
        @(negedge clk_i);
        io_off = off;
        io_rd = 1'b1;
        @(negedge clk_i);
        io_rd = 1'b0;
        chk("rdata", e, io_rdata);
    endtask
    task automatic pins(input logic [5:0] e);
        chk("pins", {10'h000, e}, {10'h000, oe, dpo, dmo});
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic test_done();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {io_wr, io_rd, gsusp, grst, eof2, busy, tdp, tdm, toe} = '0;
        {io_off, io_be, att, ls, kst, io_wdata} = '0;
        wt(4);
        rst_n_i = 1'b1;
        rd(8'h10, 16'h0080);
        rd(8'h12, 16'h0080);
        att = 2'h3;
        ls = 2'h2;
        wt(256);
        rd(8'h10, 16'h0083);
        rd(8'h12, 16'h0183);
        @(negedge clk_i) eof2 = 1'b1;
        @(negedge clk_i) eof2 = 1'b0;
        rd(8'h10, 16'h0093);
        rd(8'h12, 16'h01A3);
        wr(8'h12, 16'h0102, 2'h3);
        rd(8'h12, 16'h01A1);
        wr(8'h10, 16'h0002, 2'h3);
        wr(8'h10, 16'h0004, 2'h1);
        rd(8'h10, 16'h0091);
        wr(8'h10, 16'h0004, 2'h3);
        rd(8'h10, 16'h0095);
        busy = 1'b1;
        wr(8'h10, 16'h0000, 2'h3);
        rd(8'h10, 16'h0095);
        busy = 1'b0;
        rd(8'h10, 16'h0091);
        wr(8'h10, 16'h0004, 2'h3);
        busy = 1'b1;
        wr(8'h10, 16'h1004, 2'h3);
        wt(10);
        rd(8'h10, 16'h0095);
        busy = 1'b0;
        wt(3);
        rd(8'h10, 16'h1095);
        tdm = 1'b1;
        toe = 1'b1;
        wt(3);
        pins(6'h00);
        grst = 1'b1;
        wt(2);
        pins(6'h30);
        grst = 1'b0;
        wt(2);
        gsusp = 1'b1;
        kst[0] = 1'b1;
        wt(6);
        kst[0] = 1'b0;
        rd(8'h10, 16'h10D5);
        chk("resume_req", 16'h0001, n_res);
        pins(6'h11);
        gsusp = 1'b0;
        wr(8'h10, 16'h1004, 2'h3);
        wt(8);
        pins(6'h10);
        rd(8'h10, 16'h10D5);
        wt(68);
        pins(6'h14);
        wt(40);
        rd(8'h10, 16'h1095);
        pins(6'h00);
        wr(8'h10, 16'h0004, 2'h3);
        wt(3);
        pins(6'h11);
        wr(8'h10, 16'h0200, 2'h3);
        wt(3);
        pins(6'h10);
        rd(8'h10, 16'h0291);
        toe = 1'b0;
        wr(8'h10, 16'h0000, 2'h3);
        wr(8'h10, 16'h0004, 2'h3);
        busy = 1'b1;
        @(negedge clk_i) eof2 = 1'b1;
        @(negedge clk_i) eof2 = 1'b0;
        busy = 1'b0;
        rd(8'h10, 16'h0099);
        wr(8'h10, 16'h0008, 2'h3);
        rd(8'h10, 16'h0091);
        wr(8'h12, 16'h0004, 2'h3);
        att[1] = 1'b0;
        wt(256);
        rd(8'h12, 16'h00AA);
        rd(8'h14, 16'h00AA);
        test_done();
    end
endmodule
